// >>> bench/oer_osc_model.sv
// partner model: oscillators and multiplier that answer the block's run controls
// assumes run controls change on sys_clk; ready follows after one or four cycles
`timescale 1ns/1ps
module oer_osc_model (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire oer_pkg::oer_osc_s osc_run, // run controls from the block
    input wire logic mult_run, // multiplier run control
    input wire logic slow, // long start-up when high
    input wire logic lock_en, // multiplier may lock when high
    output oer_pkg::oer_osc_s osc_ready, // ready levels to the block
    output logic mult_lock // multiplier lock level
);
    logic [3:0][6:0] start_reg; // run history, newest in slot 0
    logic [6:0] run_v; // run controls as a plain vector
    logic [6:0] rdy_v; // ready levels as a plain vector
    assign run_v = osc_run;
    // a stopped oscillator loses ready at once, a started one needs its start-up span
    // per source: slow start needs four cycles of run history, fast start one
    assign rdy_v = slow ? (start_reg[3] & start_reg[2] & start_reg[1] & start_reg[0] & run_v)
        : (start_reg[0] & run_v);
    assign osc_ready = oer_pkg::oer_osc_s'(rdy_v);
    // run history and multiplier lock
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            start_reg <= '0;
            mult_lock <= 1'h0;
        end
        else
        begin
            start_reg <= {start_reg[2:0], run_v};
            mult_lock <= lock_en & mult_run; // locks only while running
        end
    end
endmodule : oer_osc_model

// >>> bench/oscillator_enable_ready_tb.sv
// self-checking bench for the oscillator enable/ready block over AXI4-Lite
// assumes oer_osc_model as the oscillators and the bench as the peripherals
`timescale 1ns/1ps
module oscillator_enable_ready_tb;
    localparam int NP = 2; // requesters per source
    localparam logic [1:0] OK = oer_pkg::RESP_OKAY; // okay response
    localparam logic [11:0] A_NEW = oer_pkg::IDX_NEW_SEL << 2; // byte addresses
    localparam logic [11:0] A_CUR = oer_pkg::IDX_CUR_STAT << 2;
    localparam logic [11:0] A_SW = oer_pkg::IDX_SW_CTRL << 2;
    localparam logic [11:0] A_RDY = oer_pkg::IDX_READY << 2;
    localparam logic [11:0] A_EN = oer_pkg::IDX_ENABLES << 2;
    localparam logic [11:0] A_TRIM = oer_pkg::IDX_TRIM << 2;
    localparam logic [11:0] A_FRQ = oer_pkg::IDX_FREQ << 2;
    localparam logic [11:0] A_TUNE = oer_pkg::IDX_TUNE << 2;
    logic sys_clk = 1'h0; // 100 MHz clock
    logic resetn = 1'h0; // reset, active low
    logic [11:0] awaddr = 12'h000, araddr = 12'h000; // bus addresses
    logic [31:0] wdata = 32'h0; // write data
    logic [3:0] wstrb = 4'h0; // byte enables
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0; // write handshakes
    logic arvalid = 1'h0, rready = 1'h0; // read handshakes
    logic awready, wready, bvalid, arready, rvalid; // slave handshakes
    logic [1:0] bresp, rresp; // responses
    logic [31:0] rdata; // read data
    logic [6:0][NP-1:0] req = '0; // peripheral requests
    logic slow = 1'h0, lock_en = 1'h0; // partner model controls
    oer_pkg::oer_osc_s osc_ready, osc_run; // oscillator levels
    logic mult_lock, mult_run, ext_x4, sec_high_power; // side outputs
    logic [2:0] hf_freq_code; // applied frequency code
    logic [5:0] hf_trim; // applied trim
    int checked = 0; // comparisons made
    int n_mismatch = 0; // mismatches seen
    always #5 sys_clk = ~sys_clk;
    oer_top #(.NPER(NP)) uut (.SYS_CLK(sys_clk), .RESETN(resetn), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .PERIPH_REQ(req), .OSC_READY(osc_ready), .MULT_LOCK(mult_lock),
        .OSC_RUN(osc_run), .MULT_RUN(mult_run), .PERIPH_EXT_X4(ext_x4),
        .SEC_HIGH_POWER(sec_high_power), .HF_FREQ_CODE(hf_freq_code), .HF_TRIM(hf_trim));
    oer_osc_model partner (.sys_clk(sys_clk), .resetn(resetn), .osc_run(osc_run),
        .mult_run(mult_run), .slow(slow), .lock_en(lock_en), .osc_ready(osc_ready),
        .mult_lock(mult_lock));
    // compare one value, count and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one write: address and data offered together, response awaited
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= {24'h0, d};
        wstrb <= s;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid)
            begin
                chk(32'(bresp), 32'(er));
                bready <= 1'h0;
                break;
            end
        end
    endtask : wr
    // one read: address held until taken, data and response compared
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid)
            begin
                chk(rdata, ed);
                chk(32'(rresp), 32'(er));
                rready <= 1'h0;
                break;
            end
        end
    endtask : rd
    // let run and ready paths land
    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : settle
    // verdict and end of run
    task automatic summarize;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // hang guard
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
    // main sequence
    initial
    begin
        logic [6:0][NP-1:0] t;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'h1;
        settle();
        chk(32'(sec_high_power), 32'h1);
        for (int i = 0; i < 8; i++) rd(A_NEW + 12'(4 * i), (i == 2) ? 32'h40 : 32'h0, OK);
        rd(12'h000, 32'h0, oer_pkg::RESP_SLVERR);
        wr(12'hFFC, 8'hFF, 4'h1, oer_pkg::RESP_SLVERR);
        wr(A_NEW, 8'h35, 4'h1, OK);
        wr(A_EN, 8'hFF, 4'h1, OK);
        rd(A_EN, 32'hFD, OK);
        for (int b = 2; b < 8; b++)
        begin
            wr(A_EN, 8'(1 << b), 4'h1, OK);
            settle();
            chk(32'(osc_run), 32'(1 << (b - 1)));
        end
        wr(A_EN, 8'hFF, 4'h1, OK);
        settle();
        chk(32'({mult_run, ext_x4}), 32'h3);
        rd(A_RDY, 32'hFC, OK);
        @(posedge sys_clk);
        lock_en <= 1'h1;
        settle();
        rd(A_RDY, 32'hFD, OK);
        wr(A_EN, 8'h01, 4'h1, OK);
        settle();
        rd(A_RDY, 32'h00, OK);
        wr(A_EN, 8'hFE, 4'h1, OK);
        settle();
        chk(32'({mult_run, ext_x4}), 32'h0);
        rd(A_RDY, 32'hFC, OK);
        rd(A_CUR, 32'h35, OK);
        chk(32'(hf_freq_code), 32'h0);
        wr(A_EN, 8'h00, 4'h1, OK);
        for (int i = 0; i < 7; i++)
        begin
            t = '0;
            t[i][i % NP] = 1'h1;
            @(posedge sys_clk);
            req <= t;
            settle();
            chk(32'(osc_run), 32'(1 << i));
            rd(A_RDY, 32'(2 << i), OK);
        end
        @(posedge sys_clk);
        req <= '0;
        slow <= 1'h1;
        wr(A_EN, 8'h04, 4'h1, OK);
        rd(A_RDY, 32'h00, OK);
        settle();
        rd(A_RDY, 32'h04, OK);
        wr(A_EN, 8'h00, 4'h1, OK);
        settle();
        rd(A_RDY, 32'h00, OK);
        wr(A_EN, 8'hFF, 4'h0, OK);
        wr(A_RDY, 8'hFF, 4'h1, OK);
        rd(A_EN, 32'h00, OK);
        rd(A_RDY, 32'h00, OK);
        wr(A_SW, 8'h00, 4'h1, OK);
        settle();
        chk(32'(sec_high_power), 32'h0);
        wr(A_SW, 8'hFF, 4'h1, OK);
        rd(A_SW, 32'hC0, OK);
        settle();
        chk(32'(sec_high_power), 32'h1);
        wr(A_TRIM, 8'hFF, 4'h1, OK);
        rd(A_TRIM, 32'h3F, OK);
        chk(32'(hf_trim), 32'h3F);
        for (int c = 0; c < 8; c++)
        begin
            wr(A_FRQ, 8'(c), 4'h1, OK);
            rd(A_FRQ, 32'(c), OK);
            settle();
            chk(32'(hf_freq_code), (c > 5) ? 32'h5 : 32'(c));
        end
        wr(A_TUNE, 8'hFF, 4'h1, OK);
        rd(A_TUNE, 32'hC0, OK);
        // mid-run reset with the bus idle: registers and outputs return to reset values
        @(posedge sys_clk);
        resetn <= 1'h0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'h1;
        settle();
        chk(32'({sec_high_power, hf_freq_code}), 32'h8);
        rd(A_SW, 32'h40, OK);
        rd(A_TUNE, 32'h00, OK);
        rd(A_FRQ, 32'h00, OK);
        summarize();
    end
endmodule : oscillator_enable_ready_tb

// >>> design/oer_pkg.sv
// oscillator enable/ready block: register indices, field positions, reset values, types
// assumes a single system clock domain and an AXI4-Lite register bus with 32-bit data
package oer_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_NEW_SEL = 12'h28D; // new_clock_select
    localparam logic [11:0] IDX_CUR_STAT = 12'h28E; // current_clock_status
    localparam logic [11:0] IDX_SW_CTRL = 12'h28F; // clock_switch_control
    localparam logic [11:0] IDX_READY = 12'h290; // oscillator_ready_flags
    localparam logic [11:0] IDX_ENABLES = 12'h291; // oscillator_enables
    localparam logic [11:0] IDX_TRIM = 12'h292; // internal_freq_trim
    localparam logic [11:0] IDX_FREQ = 12'h293; // internal_freq_select
    localparam logic [11:0] IDX_TUNE = 12'h294; // active_tuning_control
    // bit positions in oscillator_enables and oscillator_ready_flags
    localparam int EXT_BIT = 7; // external oscillator
    localparam int ADC_BIT = 2; // converter rc oscillator
    localparam int FAST_BIT = 1; // fast internal oscillator, no enable
    localparam int MULT_BIT = 0; // 4x multiplier
    // bit positions in clock_switch_control
    localparam int HOLD_BIT = 7; // switch hold control
    localparam int PWR_BIT = 6; // secondary power select
    // writable masks and reset values
    localparam logic [7:0] NEW_SEL_MASK = 8'h7F; // select and divider fields
    localparam logic [7:0] SW_CTRL_MASK = 8'hC0; // hold and power bits
    localparam logic [7:0] ENABLES_MASK = 8'hFD; // bit 1 unimplemented
    localparam logic [7:0] TRIM_MASK = 8'h3F; // six trim bits
    localparam logic [7:0] FREQ_MASK = 8'h07; // three code bits
    localparam logic [7:0] TUNE_MASK = 8'hC0; // tuning enable and update
    localparam logic [7:0] SW_CTRL_RST = 8'h40; // high power after reset
    localparam logic [7:0] ZERO_RST = 8'h00; // all other registers
    // highest valid frequency code: 000..101 give 1..32 MHz
    localparam logic [2:0] FREQ_MAX = 3'h5;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // per-source run or ready vector, ordered like status bits 7..1
    typedef struct packed {
        logic ext; // external oscillator
        logic hf; // high-frequency internal
        logic mf; // medium-frequency internal
        logic lf; // low-frequency internal
        logic sec; // secondary oscillator
        logic adc; // converter rc oscillator
        logic fast; // fast internal oscillator
    } oer_osc_s;
    // write channel states
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0, // gathering address and data
        WR_RESP = 1'b1 // response pending
    } oer_wr_e;
endpackage : oer_pkg

// >>> design/oer_top.sv
// oscillator enable/ready register logic with an AXI4-Lite slave
// assumes peripherals raise request levels synchronous to SYS_CLK; analog
// oscillators report ready and multiplier lock as synchronous levels
`timescale 1ns/1ps
//
// Contract
// - status bit 2: converter rc ready
// - status bit 1: fast internal ready
// - multiplier ready needs enable, source, lock
// - bit 7 forces external oscillator on
// - bit 6 keeps high-frequency oscillator running
// - bit 5 keeps medium-frequency oscillator running
// - bit 4 keeps low-frequency oscillator running
// - bit 3 keeps secondary oscillator running
// - bit 2 keeps converter rc running
// - bit 0 selects 4x external for peripherals
// - multiplier never touches system clock
// - power select one means high power
// - frequency codes 110, 111 reserved
module oer_top #(
    parameter int NPER = 4 // requesters per oscillator source
) (
    input wire logic SYS_CLK, // system clock, 100 MHz
    input wire logic RESETN, // synchronous reset, active low
    input wire logic [11:0] AWADDR, // write address
    input wire logic AWVALID, // write address valid
    output logic AWREADY, // write address ready
    input wire logic [31:0] WDATA, // write data
    input wire logic [3:0] WSTRB, // write byte enables
    input wire logic WVALID, // write data valid
    output logic WREADY, // write data ready
    output logic [1:0] BRESP, // write response
    output logic BVALID, // write response valid
    input wire logic BREADY, // write response ready
    input wire logic [11:0] ARADDR, // read address
    input wire logic ARVALID, // read address valid
    output logic ARREADY, // read address ready
    output logic [31:0] RDATA, // read data
    output logic [1:0] RRESP, // read response
    output logic RVALID, // read data valid
    input wire logic RREADY, // read data ready
    input wire logic [6:0][NPER-1:0] PERIPH_REQ, // requests per source
    input wire oer_pkg::oer_osc_s OSC_READY, // oscillator ready levels
    input wire logic MULT_LOCK, // multiplier lock level
    output oer_pkg::oer_osc_s OSC_RUN, // oscillator run controls
    output logic MULT_RUN, // multiplier run control
    output logic PERIPH_EXT_X4, // peripheral external clock is 4x
    output logic SEC_HIGH_POWER, // secondary oscillator high power
    output logic [2:0] HF_FREQ_CODE, // applied frequency code
    output logic [5:0] HF_TRIM // high-frequency trim
);
    // parameter check
    if (NPER < 1)
    begin : g_bad_nper
        $error("NPER must be at least one");
    end

    // byte addresses derived from register indices
    localparam logic [11:0] A_NEW_SEL = {oer_pkg::IDX_NEW_SEL[9:0], 2'b00};
    localparam logic [11:0] A_CUR_STAT = {oer_pkg::IDX_CUR_STAT[9:0], 2'b00};
    localparam logic [11:0] A_SW_CTRL = {oer_pkg::IDX_SW_CTRL[9:0], 2'b00};
    localparam logic [11:0] A_READY = {oer_pkg::IDX_READY[9:0], 2'b00};
    localparam logic [11:0] A_ENABLES = {oer_pkg::IDX_ENABLES[9:0], 2'b00};
    localparam logic [11:0] A_TRIM = {oer_pkg::IDX_TRIM[9:0], 2'b00};
    localparam logic [11:0] A_FREQ = {oer_pkg::IDX_FREQ[9:0], 2'b00};
    localparam logic [11:0] A_TUNE = {oer_pkg::IDX_TUNE[9:0], 2'b00};

    // software registers
    logic [7:0] new_sel_reg; // requested source and divider
    logic [7:0] cur_stat_reg; // current source and divider
    logic [7:0] sw_ctrl_reg; // hold and power select
    logic [7:0] enables_reg; // explicit enables
    logic [7:0] trim_reg; // frequency trim
    logic [7:0] freq_reg; // frequency code as written
    logic [7:0] tune_reg; // tuning control
    logic [7:0] ready_reg; // ready flags snapshot

    // bus state
    oer_pkg::oer_wr_e wr_state_reg; // write channel state
    logic aw_got_reg; // address captured
    logic w_got_reg; // data captured
    logic [11:0] waddr_reg; // captured write address
    logic [31:0] wdata_reg; // captured write data
    logic [3:0] wstrb_reg; // captured byte enables

    // per-source request reduction
    logic [6:0] req_any; // any peripheral asks for source
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_req
            assign req_any[gi] = |PERIPH_REQ[gi];
        end
    endgenerate

    // run controls: explicit enable or any request; bit 1 enable never set
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
            OSC_RUN <= '0;
        else
            OSC_RUN <= oer_pkg::oer_osc_s'(enables_reg[7:1] | req_any);
    end

    // multiplier controls apply only to the peripheral external path
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            MULT_RUN <= 1'b0;
            PERIPH_EXT_X4 <= 1'b0;
        end
        else
        begin
            MULT_RUN <= enables_reg[oer_pkg::MULT_BIT];
            PERIPH_EXT_X4 <= enables_reg[oer_pkg::MULT_BIT];
        end
    end

    // oscillator configuration outputs
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            SEC_HIGH_POWER <= oer_pkg::SW_CTRL_RST[oer_pkg::PWR_BIT];
            HF_FREQ_CODE <= oer_pkg::ZERO_RST[2:0];
            HF_TRIM <= oer_pkg::ZERO_RST[5:0];
        end
        else
        begin
            SEC_HIGH_POWER <= sw_ctrl_reg[oer_pkg::PWR_BIT];
            HF_TRIM <= trim_reg[5:0];
            // reserved codes leave the applied frequency unchanged
            if (freq_reg[2:0] <= oer_pkg::FREQ_MAX)
                HF_FREQ_CODE <= freq_reg[2:0];
        end
    end

    // ready flags: running and reported ready by the oscillator
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
            ready_reg <= oer_pkg::ZERO_RST;
        else
        begin
            ready_reg[7:1] <= OSC_RUN & OSC_READY;
            ready_reg[oer_pkg::MULT_BIT] <= MULT_RUN & OSC_READY.ext & MULT_LOCK;
        end
    end

    // write channel: take address and data in any order, then respond
    logic wr_hit; // address is mapped, decoded below from the captured address
    wire wr_fire = (wr_state_reg == oer_pkg::WR_COLLECT) && aw_got_reg && w_got_reg;
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            wr_state_reg <= oer_pkg::WR_COLLECT;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= oer_pkg::RESP_OKAY;
        end
        else
        begin
            case (wr_state_reg)
                oer_pkg::WR_COLLECT:
                begin
                    // capture address
                    if (AWVALID && AWREADY)
                    begin
                        aw_got_reg <= 1'b1;
                        waddr_reg <= AWADDR;
                    end
                    // capture data
                    if (WVALID && WREADY)
                    begin
                        w_got_reg <= 1'b1;
                        wdata_reg <= WDATA;
                        wstrb_reg <= WSTRB;
                    end
                    AWREADY <= !(aw_got_reg || (AWVALID && AWREADY));
                    WREADY <= !(w_got_reg || (WVALID && WREADY));
                    // both held: perform write and respond
                    if (wr_fire)
                    begin
                        wr_state_reg <= oer_pkg::WR_RESP;
                        BVALID <= 1'b1;
                        BRESP <= wr_hit ? oer_pkg::RESP_OKAY : oer_pkg::RESP_SLVERR;
                        AWREADY <= 1'b0;
                        WREADY <= 1'b0;
                    end
                end
                oer_pkg::WR_RESP:
                begin
                    // wait for the master to take the response
                    if (BREADY)
                    begin
                        BVALID <= 1'b0;
                        aw_got_reg <= 1'b0;
                        w_got_reg <= 1'b0;
                        AWREADY <= 1'b1;
                        WREADY <= 1'b1;
                        wr_state_reg <= oer_pkg::WR_COLLECT;
                    end
                end
                default:
                    wr_state_reg <= oer_pkg::WR_COLLECT;
            endcase
        end
    end

    // write decode: all eight mapped registers; status registers accept and ignore
    always_comb
    begin
        case (waddr_reg)
            A_NEW_SEL, A_CUR_STAT, A_SW_CTRL, A_READY,
            A_ENABLES, A_TRIM, A_FREQ, A_TUNE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end
    wire wr_lane = wr_fire && wstrb_reg[0]; // only byte lane 0 holds data

    // register storage
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            new_sel_reg <= oer_pkg::ZERO_RST;
            cur_stat_reg <= oer_pkg::ZERO_RST;
            sw_ctrl_reg <= oer_pkg::SW_CTRL_RST;
            enables_reg <= oer_pkg::ZERO_RST;
            trim_reg <= oer_pkg::ZERO_RST;
            freq_reg <= oer_pkg::ZERO_RST;
            tune_reg <= oer_pkg::ZERO_RST;
        end
        else
        begin
            // switch sequencing is outside this block: current follows new
            cur_stat_reg <= new_sel_reg;
            if (wr_lane && waddr_reg == A_NEW_SEL)
                new_sel_reg <= wdata_reg[7:0] & oer_pkg::NEW_SEL_MASK;
            if (wr_lane && waddr_reg == A_SW_CTRL)
                sw_ctrl_reg <= wdata_reg[7:0] & oer_pkg::SW_CTRL_MASK;
            if (wr_lane && waddr_reg == A_ENABLES)
                enables_reg <= wdata_reg[7:0] & oer_pkg::ENABLES_MASK;
            if (wr_lane && waddr_reg == A_TRIM)
                trim_reg <= wdata_reg[7:0] & oer_pkg::TRIM_MASK;
            if (wr_lane && waddr_reg == A_FREQ)
                freq_reg <= wdata_reg[7:0] & oer_pkg::FREQ_MASK;
            if (wr_lane && waddr_reg == A_TUNE)
                tune_reg <= wdata_reg[7:0] & oer_pkg::TUNE_MASK;
        end
    end

    // read decode
    logic [7:0] rd_byte; // selected register
    logic rd_hit; // address is mapped
    always_comb
    begin
        rd_hit = 1'b1;
        case (ARADDR)
            A_NEW_SEL: rd_byte = new_sel_reg;
            A_CUR_STAT: rd_byte = cur_stat_reg;
            A_SW_CTRL: rd_byte = sw_ctrl_reg;
            A_READY: rd_byte = ready_reg;
            A_ENABLES: rd_byte = enables_reg;
            A_TRIM: rd_byte = trim_reg;
            A_FREQ: rd_byte = freq_reg;
            A_TUNE: rd_byte = tune_reg;
            default:
            begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel: one read at a time, data one cycle after the address
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= oer_pkg::RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= {24'h00_0000, rd_byte};
            RRESP <= rd_hit ? oer_pkg::RESP_OKAY : oer_pkg::RESP_SLVERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
        else if (!RVALID)
            ARREADY <= 1'b1;
    end

    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    adc_ready_a: assert property (##1 ready_reg[oer_pkg::ADC_BIT] == $past(OSC_RUN.adc && OSC_READY.adc))
        else $error("converter rc ready flag wrong");
    fast_ready_a: assert property (##1 ready_reg[oer_pkg::FAST_BIT] == $past(OSC_RUN.fast && OSC_READY.fast))
        else $error("fast internal ready flag wrong");
    mult_ready_a: assert property (!enables_reg[oer_pkg::MULT_BIT] |-> ##2 !ready_reg[oer_pkg::MULT_BIT])
        else $error("multiplier ready while disabled");
    ext_run_a: assert property (enables_reg[oer_pkg::EXT_BIT] |=> OSC_RUN.ext)
        else $error("external oscillator not forced on");
    run_or_a: assert property (##1 OSC_RUN == oer_pkg::oer_osc_s'($past(enables_reg[7:1] | req_any)))
        else $error("run controls do not follow enables and requests");
    idle_off_a: assert property ((enables_reg[6:2] == 5'h00 && req_any[5:1] == 5'h00) |=> OSC_RUN[5:1] == 5'h00)
        else $error("oscillator running without enable or request");
    x4_sel_a: assert property (##1 PERIPH_EXT_X4 == $past(enables_reg[oer_pkg::MULT_BIT]))
        else $error("peripheral 4x select does not follow enable bit 0");
    pwr_mode_a: assert property ($changed(sw_ctrl_reg[oer_pkg::PWR_BIT]) |=> SEC_HIGH_POWER == $past(sw_ctrl_reg[oer_pkg::PWR_BIT]))
        else $error("secondary power mode not applied");
    freq_rsv_a: assert property (HF_FREQ_CODE <= oer_pkg::FREQ_MAX)
        else $error("reserved frequency code applied");
    bit1_zero_a: assert property (!enables_reg[oer_pkg::FAST_BIT])
        else $error("unimplemented enable bit set");

    wr_cov_c: cover property (BVALID && BREADY && BRESP == oer_pkg::RESP_OKAY);
    rd_cov_c: cover property (RVALID && RREADY && RRESP == oer_pkg::RESP_SLVERR);
    mult_cov_c: cover property (ready_reg[oer_pkg::MULT_BIT]);
    req_cov_c: cover property (OSC_RUN.adc && !enables_reg[oer_pkg::ADC_BIT]);
endmodule : oer_top
